// ==== design/ncd_pkg.sv ====
// package: register map, field layout and constants of the nvm clock divider
package ncd_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] RATIO_OFFS  = 8'h00;   // flash_clock_ratio
  localparam logic [7:0] NVCFG_OFFS  = 8'h04;   // working copies of the two nv locations
  localparam logic [7:0] STAT_OFFS   = 8'h08;   // access error status
  localparam logic [7:0] CMD_OFFS    = 8'h0c;   // nv write / command request
  // ==========================================================
  // field positions
  localparam int LOADED_BIT   = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIVISOR_MSB  = 5;
  localparam int ACCERR_BIT   = 0;
  localparam int BUSY_BIT     = 1;
  // ==========================================================
  // reset values and counts
  localparam logic [6:0] RATIO_RST    = 7'h00;
  localparam logic [2:0] PRESCALE_MAX = 3'h7;   // divide by eight
  localparam logic [7:0] OP_PULSES    = 8'h04;  // timing ticks per nv operation
  localparam logic [1:0] AXI_OKAY     = 2'b00;
  localparam logic [1:0] AXI_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    NCD_IDLE = 2'b00,
    NCD_RUN  = 2'b01
  } ncd_op_t;
endpackage

// ==== design/ncd_tick_if.sv ====
// interface: timing tick and divider setting between top and tick generator
`timescale 1ns/1ps
interface ncd_tick_if;
  logic       prescale;
  logic [5:0] divisor;
  logic       run;
  logic       tick;
  modport gen (input prescale, input divisor, input run, output tick);
  modport use_side (output prescale, output divisor, output run, input tick);
endinterface

// ==== design/ncd_tick_gen.sv ====
// module: prescaler and divisor counter producing one-cycle timing ticks; with divisor zero and prescale off the tick stays high
`timescale 1ns/1ps
module ncd_tick_gen
  import ncd_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   sys_rst_i,
  ncd_tick_if.gen     tk
);
  logic [2:0] pre_q, pre_d;
  logic [5:0] div_q, div_d;
  logic       tick_q, tick_d;
  logic       pre_en;

  // ==========================================================
  // prescale stage: enable every cycle, or every eighth cycle
  always_comb begin
    pre_en = tk.prescale ? (pre_q == PRESCALE_MAX) : 1'b1;
    pre_d  = tk.run ? pre_q + 3'h1 : 3'h0;
    div_d  = div_q;
    tick_d = 1'b0;
    if (!tk.run) begin
      div_d = 6'h00;
    end else if (pre_en) begin
      // divide by divisor plus one
      if (div_q >= tk.divisor) begin
        div_d  = 6'h00;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_q  <= 3'h0;
      div_q  <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

  a_tick_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick_q |=> !tick_q) else $error("tick lasted more than one cycle");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tick_q && !tk.prescale && tk.run && $stable(tk.divisor) && tk.divisor == 6'h03)
    |=> !tick_q [*3] ##1 tick_q) else $error("tick spacing differs from divisor plus one");
  a_prescale_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tick_q && tk.prescale && tk.run && tk.divisor == 6'h00)
    |=> !tick_q [*7] ##1 tick_q) else $error("prescaled tick not every eighth cycle");
endmodule

// ==== design/ncd_top.sv ====
// module: nvm clock divider register block with axi4-lite slave
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// Operation
// - reset clears the loaded flag; writes to bit seven never change it
// - first write after reset sets the loaded flag, any data
// - erase and program stay disabled until the loaded flag is one
// - only the first write lands in bits six to zero; reads always allowed
// - prescale bit one feeds the divider with bus clock over eight
// - divider divides its input by the six-bit divisor plus one
// - each timing pulse is one timing period; operations count whole pulses
// - reset copies two nonvolatile locations into two working registers
// - nv write before the ratio is loaded is an access error, not started
module ncd_top
  import ncd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // nonvolatile side
  input  wire logic [7:0]  nv_prot_i,
  input  wire logic [7:0]  nv_opt_i,
  output      logic        nv_op_enable_o,
  output      logic        nvm_timing_clock_o,
  output      logic        nv_op_busy_o,
  output      logic        nv_op_done_o
);
  ncd_tick_if tk ();

  logic        ratio_loaded_flag_q, ratio_loaded_flag_d;
  logic [6:0]  ratio_q, ratio_d;
  logic [7:0]  prot_q, prot_d, opt_q, opt_d;
  logic        load_nv_q, load_nv_d;
  logic        accerr_q, accerr_d;
  ncd_op_t     op_q, op_d;
  logic [7:0]  pulse_q, pulse_d;
  logic        done_q, done_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        wr_fire;

  // word address decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a == RATIO_OFFS) || (a == NVCFG_OFFS) || (a == STAT_OFFS) || (a == CMD_OFFS);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      RATIO_OFFS: v = {24'h000000, ratio_loaded_flag_q, ratio_q};
      NVCFG_OFFS: v = {16'h0000, opt_q, prot_q};
      STAT_OFFS:  v = {30'h0000_0000, (op_q == NCD_RUN), accerr_q};
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================================
  // axi write channel: capture address and data in either order
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = mapped(awa_q) ? AXI_OKAY : AXI_SLVERR;
    end else if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign wr_fire       = aw_q && w_q && !bv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;

  // ==========================================================
  // axi read channel: one cycle from address to data
  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rd_d = read_word({s_axi_araddr[7:2], 2'b00});
      rr_d = mapped({s_axi_araddr[7:2], 2'b00}) ? AXI_OKAY : AXI_SLVERR;
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ==========================================================
  // ratio register: write once, loaded flag set by the first write
  always_comb begin
    ratio_loaded_flag_d = ratio_loaded_flag_q;
    ratio_d             = ratio_q;
    if (wr_fire && awa_q == RATIO_OFFS && !ratio_loaded_flag_q) begin
      ratio_loaded_flag_d = 1'b1;
      // a cleared low byte strobe still counts as the write
      if (ws_q[0]) begin
        ratio_d = wd_q[6:0];                              // bit seven ignored
      end
    end
  end

  // ==========================================================
  // working copies loaded once, on the first cycle after reset
  always_comb begin
    load_nv_d = 1'b0;
    prot_d    = prot_q;
    opt_d     = opt_q;
    if (load_nv_q) begin
      prot_d = nv_prot_i;
      opt_d  = nv_opt_i;
    end
  end

  // ==========================================================
  // nv operation: gated by the loaded flag, timed in whole ticks
  always_comb begin
    op_d     = op_q;
    pulse_d  = pulse_q;
    accerr_d = accerr_q;
    done_d   = 1'b0;
    if (wr_fire && awa_q == STAT_OFFS && ws_q[0] && wd_q[ACCERR_BIT]) begin
      accerr_d = 1'b0;                                    // write one to clear
    end
    if (wr_fire && awa_q == CMD_OFFS) begin
      if (!ratio_loaded_flag_q || op_q == NCD_RUN) begin
        accerr_d = 1'b1;                                  // set wins over clear
      end else begin
        op_d    = NCD_RUN;
        pulse_d = OP_PULSES;
      end
    end
    if (op_q == NCD_RUN && tk.tick) begin
      if (pulse_q == 8'h01) begin
        op_d   = NCD_IDLE;
        done_d = 1'b1;
      end
      pulse_d = pulse_q - 8'h01;
    end
  end

  assign tk.prescale = ratio_q[PRESCALE_BIT];
  assign tk.divisor  = ratio_q[DIVISOR_MSB:0];
  assign tk.run      = ratio_loaded_flag_q;

  ncd_tick_gen u_tick (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tk        (tk)
  );

  // ==========================================================
  // register stage for all state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ratio_loaded_flag_q <= 1'b0;
      ratio_q             <= RATIO_RST;
      prot_q              <= 8'h00;
      opt_q               <= 8'h00;
      load_nv_q           <= 1'b1;
      accerr_q            <= 1'b0;
      op_q                <= NCD_IDLE;
      pulse_q             <= 8'h00;
      done_q              <= 1'b0;
      aw_q                <= 1'b0;
      w_q                 <= 1'b0;
      bv_q                <= 1'b0;
      rv_q                <= 1'b0;
      awa_q               <= 8'h00;
      wd_q                <= 32'h0000_0000;
      ws_q                <= 4'h0;
      rd_q                <= 32'h0000_0000;
      br_q                <= AXI_OKAY;
      rr_q                <= AXI_OKAY;
    end else begin
      ratio_loaded_flag_q <= ratio_loaded_flag_d;
      ratio_q             <= ratio_d;
      prot_q              <= prot_d;
      opt_q               <= opt_d;
      load_nv_q           <= load_nv_d;
      accerr_q            <= accerr_d;
      op_q                <= op_d;
      pulse_q             <= pulse_d;
      done_q              <= done_d;
      aw_q                <= aw_d;
      w_q                 <= w_d;
      bv_q                <= bv_d;
      rv_q                <= rv_d;
      awa_q               <= awa_d;
      wd_q                <= wd_d;
      ws_q                <= ws_d;
      rd_q                <= rd_d;
      br_q                <= br_d;
      rr_q                <= rr_d;
    end
  end

  assign nv_op_enable_o     = ratio_loaded_flag_q;
  assign nvm_timing_clock_o = tk.tick;
  assign nv_op_busy_o       = (op_q == NCD_RUN);
  assign nv_op_done_o       = done_q;

  // ==========================================================
  // checks
  sequence s_first_ratio_write;
    wr_fire && awa_q == RATIO_OFFS && !ratio_loaded_flag_q;
  endsequence

  a_loaded_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_first_ratio_write |=> ratio_loaded_flag_q) else $error("loaded flag not set");
  a_loaded_sticks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ratio_loaded_flag_q |=> ratio_loaded_flag_q) else $error("loaded flag dropped");
  a_reset_clears: assert property (@(posedge clk_i)
    sys_rst_i |=> !ratio_loaded_flag_q && ratio_q == RATIO_RST) else $error("reset value");
  a_ratio_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ratio_loaded_flag_q |=> $stable(ratio_q)) else $error("ratio changed after load");
  a_op_gated: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ratio_loaded_flag_q |-> op_q == NCD_IDLE && !tk.tick) else $error("op while unloaded");
  a_early_error: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_fire && awa_q == CMD_OFFS && !ratio_loaded_flag_q)
    |=> accerr_q && op_q == NCD_IDLE) else $error("early nv write not refused");
  a_nv_copy: assert property (@(posedge clk_i)
    sys_rst_i ##1 !sys_rst_i |=> prot_q == $past(nv_prot_i) && opt_q == $past(nv_opt_i))
    else $error("nv copy missing");
  a_op_ends_tick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(op_q == NCD_RUN) |-> $past(tk.tick) && $past(pulse_q) == 8'h01)
    else $error("op ended off a tick");
endmodule

// ==== testbench/ncd_tb.sv ====
// testbench: self-checking scenarios for the nvm clock divider register block
`timescale 1ns/1ps
module testbench
  import ncd_pkg::*;
;
  // ==========================================================
  // signals and design instance
  localparam int TIMEOUT = 20000;
  logic        clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, op_en, tick, busy, done;
  logic [7:0]  awaddr, araddr, prot, opt;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          error_cnt, compares, cycles, op_ticks;

  ncd_top ncd_top_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nv_prot_i(prot), .nv_opt_i(opt), .nv_op_enable_o(op_en),
    .nvm_timing_clock_o(tick), .nv_op_busy_o(busy), .nv_op_done_o(done)
  );

  // ==========================================================
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
    end
  end

  // ticks seen while an operation runs; counted here so none is missed during bus traffic
  always @(posedge clk_i) begin
    if (busy === 1'b1 && tick === 1'b1) op_ticks <= op_ticks + 1;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // master offers aw and w together, releases each when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // idle edge so a following call never reassigns bready in this step
    @(posedge clk_i);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // idle edge so a following call never reassigns rready in this step
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(d, exp);
  endtask

  // cycles between two ticks; tick must be a single cycle wide
  task automatic tick_period(output int n);
    n = 0;
    @(posedge clk_i);
    while (tick !== 1'b1) @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 2000);
  endtask

  // nv values change after capture so a late sample would show
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    prot      <= 8'ha5;
    opt       <= 8'h3c;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    prot <= 8'h11;
    opt  <= 8'h22;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({31'h0, op_en}, 32'h0);
    rd_chk(RATIO_OFFS, 32'h0);
    rd_chk(NVCFG_OFFS, 32'h3ca5);
    $display("test reset done");
  endtask

  task automatic t_early_cmd();
    logic [1:0] r;
    axi_write(CMD_OFFS, 32'h1, r);
    @(posedge clk_i);
    chk({31'h0, busy}, 32'h0);
    rd_chk(STAT_OFFS, 32'h1);
    axi_write(STAT_OFFS, 32'h1, r);
    rd_chk(STAT_OFFS, 32'h0);
    $display("test early command done");
  endtask

  task automatic t_load();
    logic [1:0] r;
    int         n;
    axi_write(RATIO_OFFS, 32'h03, r);
    rd_chk(RATIO_OFFS, 32'h83);
    chk({31'h0, op_en}, 32'h1);
    tick_period(n);
    chk(32'(n), 32'd4);
    @(posedge clk_i);
    chk({31'h0, tick}, 32'h0);
    axi_write(RATIO_OFFS, 32'h7f, r);
    chk({30'h0, r}, {30'h0, AXI_OKAY});
    rd_chk(RATIO_OFFS, 32'h83);
    $display("test load done");
  endtask

  // second command while busy must be refused with the error flag
  task automatic t_op();
    logic [1:0] r;
    int         n;
    n = op_ticks;
    axi_write(CMD_OFFS, 32'h1, r);
    chk({31'h0, busy}, 32'h1);
    axi_write(CMD_OFFS, 32'h1, r);
    do begin
      @(posedge clk_i);
    end while (done !== 1'b1);
    chk(32'(op_ticks - n), 32'(OP_PULSES));
    @(posedge clk_i);
    chk({31'h0, busy}, 32'h0);
    chk({31'h0, done}, 32'h0);
    rd_chk(STAT_OFFS, 32'h1);
    $display("test operation done");
  endtask

  task automatic t_unmapped();
    logic [1:0]  r;
    logic [31:0] d;
    axi_write(8'h10, 32'hff, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    axi_read(8'h10, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    $display("test unmapped done");
  endtask

  task automatic t_prescale();
    logic [1:0] r;
    int         n;
    do_reset();
    chk({31'h0, op_en}, 32'h0);
    rd_chk(NVCFG_OFFS, 32'h3ca5);
    axi_write(RATIO_OFFS, 32'h40, r);
    rd_chk(RATIO_OFFS, 32'hc0);
    tick_period(n);
    chk(32'(n), 32'd8);
    $display("test prescale done");
  endtask

  // legal setting on a 100 MHz bus: 100 MHz over 8 * 63 is about 198 kHz
  task automatic t_legal_rate();
    logic [1:0] r;
    int         n;
    do_reset();
    axi_write(RATIO_OFFS, 32'h7e, r);
    rd_chk(RATIO_OFFS, 32'hfe);
    tick_period(n);
    chk(32'(n), 32'd504);
    $display("test legal rate done");
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {sys_rst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, prot, opt, wdata} = '0;
    error_cnt = 0;
    compares  = 0;
    @(posedge clk_i);
    do_reset();
    t_reset();
    t_early_cmd();
    t_load();
    t_op();
    t_unmapped();
    t_prescale();
    t_legal_rate();
    end_of_test();
  end
endmodule
